/* logic/nsx_datapath.sv */
`timescale 1ns/10ps
`default_nettype none
module nsx_datapath
  import nsx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              arst_n,
  input  wire logic              opValid,
  input  wire nsx_op_type        op,
  input  wire logic              dest,
  input  wire logic [ADDR_W-1:0] fileAddr,
  input  wire logic [DATA_W-1:0] literal,
  input  wire logic [DATA_W-1:0] fileRdData,
  output logic      [ADDR_W-1:0] fileRdAddr,
  output logic                   fileWe,
  output logic      [ADDR_W-1:0] fileWrAddr,
  output logic      [DATA_W-1:0] fileWrData,
  output logic      [DATA_W-1:0] accOut,
  output logic                   zeroFlag,
  output logic      [DATA_W-1:0] dirAOut,
  output logic      [DATA_W-1:0] dirBOut
);

  // --------------------------------------------------------------------------
  // combinational core
  // --------------------------------------------------------------------------
  nsx_res_if res ();
  logic [DATA_W-1:0] acc_q, acc_d, wrData_q, wrData_d, dirA_q, dirA_d;
  logic [DATA_W-1:0] dirB_q, dirB_d;
  logic [ADDR_W-1:0] wrAddr_q, wrAddr_d;
  logic              we_q, we_d, zero_q, zero_d;
  logic              fwdHit;
  logic [DATA_W-1:0] fileOperand;

  // read address is combinational so the file read lands in the same cycle
  assign fileRdAddr = fileAddr;

  // the file write lands one edge after the op, so an op that reads the
  // word written just before would see the stale value: bypass it here
  assign fwdHit      = we_q && (wrAddr_q == fileAddr);
  assign fileOperand = fwdHit ? wrData_q : fileRdData;

  nsx_core u_core (
    .op       (op),
    .dest     (dest),
    .fileAddr (fileAddr),
    .literal  (literal),
    .accIn    (acc_q),
    .fileIn   (fileOperand),
    .res      (res)
  );

  // --------------------------------------------------------------------------
  // next state
  // --------------------------------------------------------------------------
  always_comb begin
    acc_d    = acc_q;
    dirA_d   = dirA_q;
    dirB_d   = dirB_q;
    zero_d   = zero_q;
    we_d     = 1'b0;
    wrAddr_d = wrAddr_q;
    wrData_d = wrData_q;
    if (opValid) begin
      if (res.toAcc) begin
        acc_d = res.result;
      end
      if (res.toFile) begin
        we_d     = 1'b1;
        wrAddr_d = fileAddr;
        wrData_d = res.result;
      end
      if (res.toDir && !res.dirSel) begin
        dirA_d = res.result;
      end
      if (res.toDir && res.dirSel) begin
        dirB_d = res.result;
      end
      if (res.zeroWe) begin
        zero_d = res.zeroVal;
      end
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      acc_q    <= ACC_RST;
      dirA_q   <= DIR_RST;
      dirB_q   <= DIR_RST;
      zero_q   <= 1'b0;
      we_q     <= 1'b0;
      wrAddr_q <= '0;
      wrData_q <= ZERO_VAL;
    end else begin
      acc_q    <= acc_d;
      dirA_q   <= dirA_d;
      dirB_q   <= dirB_d;
      zero_q   <= zero_d;
      we_q     <= we_d;
      wrAddr_q <= wrAddr_d;
      wrData_q <= wrData_d;
    end
  end

  assign accOut     = acc_q;
  assign zeroFlag   = zero_q;
  assign dirAOut    = dirA_q;
  assign dirBOut    = dirB_q;
  assign fileWe     = we_q;
  assign fileWrAddr = wrAddr_q;
  assign fileWrData = wrData_q;

  // --------------------------------------------------------------------------
  // assertions
  // --------------------------------------------------------------------------
  property p_swap;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_NIBBLE_SWAP_OP && dest == DEST_ACC) |=>
      acc_q == {$past(fileOperand[NIB_LO +: NIB_W]),
                $past(fileOperand[NIB_HI +: NIB_W])};
  endproperty
  a_swap: assert property (p_swap)
    else $error("swap result wrong");

  property p_swap_file;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_NIBBLE_SWAP_OP && dest == DEST_FILE) |=>
      fileWe && fileWrAddr == $past(fileAddr) && $stable(acc_q) &&
      fileWrData == {$past(fileOperand[NIB_LO +: NIB_W]),
                     $past(fileOperand[NIB_HI +: NIB_W])};
  endproperty
  a_swap_file: assert property (p_swap_file)
    else $error("swap to file wrong");

  property p_swap_flag;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_NIBBLE_SWAP_OP) |=> $stable(zero_q);
  endproperty
  a_swap_flag: assert property (p_swap_flag)
    else $error("swap changed the zero flag");

  property p_dest_file;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_XOR_FILE_OP && dest == DEST_FILE) |=>
      fileWe && fileWrAddr == $past(fileAddr) && $stable(acc_q) &&
      fileWrData == ($past(acc_q) ^ $past(fileOperand));
  endproperty
  a_dest_file: assert property (p_dest_file)
    else $error("xor file result not written to file");

  property p_dest_acc;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_XOR_FILE_OP && dest == DEST_ACC) |=>
      !fileWe && acc_q == ($past(acc_q) ^ $past(fileOperand));
  endproperty
  a_dest_acc: assert property (p_dest_acc)
    else $error("xor file result not in accumulator");

  property p_fwd;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_XOR_FILE_OP && dest == DEST_ACC &&
     fileWe && fileWrAddr == fileAddr) |=>
      acc_q == ($past(acc_q) ^ $past(fileWrData));
  endproperty
  a_fwd: assert property (p_fwd)
    else $error("pending file write not seen by next op");

  property p_dir_a;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_DIRECTION_LOAD && fileAddr == DIR_SEL_A) |=>
      dirA_q == $past(acc_q) && $stable(dirB_q) && $stable(zero_q);
  endproperty
  a_dir_a: assert property (p_dir_a)
    else $error("direction load of first register wrong");

  property p_dir_b;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_DIRECTION_LOAD && fileAddr == DIR_SEL_B) |=>
      dirB_q == $past(acc_q) && $stable(dirA_q) && $stable(zero_q);
  endproperty
  a_dir_b: assert property (p_dir_b)
    else $error("direction load of second register wrong");

  property p_dir_refuse;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_DIRECTION_LOAD && fileAddr != DIR_SEL_A &&
     fileAddr != DIR_SEL_B) |=>
      $stable(dirA_q) && $stable(dirB_q) && $stable(acc_q) && !fileWe;
  endproperty
  a_dir_refuse: assert property (p_dir_refuse)
    else $error("direction load to absent register took effect");

  property p_xorlit;
    @(posedge clk) disable iff (!arst_n)
    (opValid && op == NSX_XOR_LITERAL_OP) |=>
      !fileWe && acc_q == ($past(acc_q) ^ $past(literal));
  endproperty
  a_xorlit: assert property (p_xorlit)
    else $error("xor literal result wrong");

  property p_zero;
    @(posedge clk) disable iff (!arst_n)
    (opValid && (op == NSX_XOR_FILE_OP || op == NSX_XOR_LITERAL_OP)) |=>
      zero_q == ((fileWe ? fileWrData : acc_q) == ZERO_VAL);
  endproperty
  a_zero: assert property (p_zero)
    else $error("zero flag does not match result");

  property p_idle;
    @(posedge clk) disable iff (!arst_n)
    !opValid |=> !fileWe && $stable(acc_q) && $stable(zero_q) &&
      $stable(dirA_q) && $stable(dirB_q);
  endproperty
  a_idle: assert property (p_idle)
    else $error("state changed with no op");

  c_swap: cover property (@(posedge clk) disable iff (!arst_n)
    opValid && op == NSX_NIBBLE_SWAP_OP && dest == DEST_FILE);
  c_zero: cover property (@(posedge clk) disable iff (!arst_n)
    opValid && op == NSX_XOR_FILE_OP && res.zeroVal);
  c_dir: cover property (@(posedge clk) disable iff (!arst_n)
    opValid && op == NSX_DIRECTION_LOAD && fileAddr == DIR_SEL_A);
  c_fwd: cover property (@(posedge clk) disable iff (!arst_n)
    opValid && op == NSX_XOR_FILE_OP && fwdHit);

endmodule
`default_nettype wire

/* inc/nsx_pkg.sv */
`default_nettype none
package nsx_pkg;

  // --------------------------------------------------------------------------
  // widths and fields
  // --------------------------------------------------------------------------
  localparam int DATA_W = 8;
  localparam int ADDR_W = 5;
  localparam int NIB_LO = 0;
  localparam int NIB_W  = 4;
  localparam int NIB_HI = 4;

  localparam logic [ADDR_W-1:0] DIR_SEL_A = 5'h06;
  localparam logic [ADDR_W-1:0] DIR_SEL_B = 5'h07;
  localparam logic [DATA_W-1:0] ZERO_VAL  = 8'h00;
  localparam logic [DATA_W-1:0] ACC_RST   = 8'h00;
  localparam logic [DATA_W-1:0] DIR_RST   = 8'hff;
  localparam logic              DEST_ACC  = 1'b0;
  localparam logic              DEST_FILE = 1'b1;

  // --------------------------------------------------------------------------
  // operations
  // --------------------------------------------------------------------------
  typedef enum logic [2:0] {
    NSX_NOP            = 3'h0,
    NSX_NIBBLE_SWAP_OP = 3'h1,
    NSX_XOR_FILE_OP    = 3'h3,
    NSX_XOR_LITERAL_OP = 3'h2,
    NSX_DIRECTION_LOAD = 3'h6
  } nsx_op_type;

endpackage
`default_nettype wire

/* inc/nsx_res_if.sv */
`timescale 1ns/10ps
`default_nettype none
// --------------------------------------------------------------------------
// result bundle from the combinational core to the registering top
// --------------------------------------------------------------------------
interface nsx_res_if;
  import nsx_pkg::*;
  logic [DATA_W-1:0] result;
  logic              toAcc;
  logic              toFile;
  logic              toDir;
  logic              dirSel;
  logic              zeroWe;
  logic              zeroVal;
  modport core (output result, toAcc, toFile, toDir, dirSel, zeroWe, zeroVal);
  modport top  (input  result, toAcc, toFile, toDir, dirSel, zeroWe, zeroVal);
endinterface
`default_nettype wire

/* logic/nsx_core.sv */
`timescale 1ns/10ps
`default_nettype none
module nsx_core
  import nsx_pkg::*;
(
  input  wire nsx_op_type        op,
  input  wire logic              dest,
  input  wire logic [ADDR_W-1:0] fileAddr,
  input  wire logic [DATA_W-1:0] literal,
  input  wire logic [DATA_W-1:0] accIn,
  input  wire logic [DATA_W-1:0] fileIn,
  nsx_res_if.core                res
);

  // --------------------------------------------------------------------------
  // result and destination select
  // --------------------------------------------------------------------------
  always_comb begin
    res.result  = ZERO_VAL;
    res.toAcc   = 1'b0;
    res.toFile  = 1'b0;
    res.toDir   = 1'b0;
    res.dirSel  = 1'b0;
    res.zeroWe  = 1'b0;
    case (op)
      NSX_NIBBLE_SWAP_OP: begin
        res.result = {fileIn[NIB_LO +: NIB_W],
                      fileIn[NIB_HI +: NIB_W]};
        res.toAcc  = (dest == DEST_ACC);
        res.toFile = (dest == DEST_FILE);
      end
      NSX_XOR_FILE_OP: begin
        res.result = accIn ^ fileIn;
        res.toAcc  = (dest == DEST_ACC);
        res.toFile = (dest == DEST_FILE);
        res.zeroWe = 1'b1;
      end
      NSX_XOR_LITERAL_OP: begin
        res.result = accIn ^ literal;
        res.toAcc  = 1'b1;
        res.zeroWe = 1'b1;
      end
      NSX_DIRECTION_LOAD: begin
        // other operand values are ignored: no such direction register
        res.result = accIn;
        res.toDir  = (fileAddr == DIR_SEL_A) || (fileAddr == DIR_SEL_B);
        res.dirSel = (fileAddr == DIR_SEL_B);
      end
      default: begin
        res.result = ZERO_VAL;
      end
    endcase
    res.zeroVal = (res.result == ZERO_VAL);
  end

endmodule
`default_nettype wire

/* dv/nsx_regfile_model.sv */
`timescale 1ns/10ps
`default_nettype none
module nsx_regfile_model
  import nsx_pkg::*;
(
  input  wire logic              clk,
  input  wire logic [ADDR_W-1:0] rdAddr,
  output logic      [DATA_W-1:0] rdData,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] wrAddr,
  input  wire logic [DATA_W-1:0] wrData
);
  // --------------------------------------------------------------------------
  // storage
  // --------------------------------------------------------------------------
  logic [DATA_W-1:0] mem [32];
  // each word starts as its own address so every read is traceable
  initial begin
    for (int i = 0; i < 32; i++) begin
      mem[i] = DATA_W'(i);
    end
  end
  assign rdData = mem[rdAddr];
  always @(posedge clk) begin
    if (we) begin
      mem[wrAddr] <= wrData;
    end
  end
endmodule
`default_nettype wire

/* dv/nibble_swap_xor_direction_load_op_ops_tb.sv */
`timescale 1ns/10ps
`default_nettype none
module nibble_swap_xor_direction_load_op_ops_tb
  import nsx_pkg::*;
;
  typedef struct {
    nsx_op_type op; logic dest; logic [4:0] addr; logic [7:0] lit;
    logic [7:0] acc; logic z; logic we; logic [7:0] da, db, mem;
  } nsx_row_type;
  localparam nsx_op_type XL = NSX_XOR_LITERAL_OP;
  localparam nsx_op_type XF = NSX_XOR_FILE_OP;
  localparam nsx_op_type SW = NSX_NIBBLE_SWAP_OP;
  localparam nsx_op_type DL = NSX_DIRECTION_LOAD;
  // --------------------------------------------------------------------------
  // rows run back to back; mem is the addressed word once its write lands
  // --------------------------------------------------------------------------
  nsx_row_type rows [13] = '{
    '{XL, 0, 5'h00, 8'h3c, 8'h3c, 0, 0, 8'hff, 8'hff, 8'h00},
    '{DL, 0, 5'h06, 8'h00, 8'h3c, 0, 0, 8'h3c, 8'hff, 8'h06},
    '{XL, 0, 5'h00, 8'h3c, 8'h00, 1, 0, 8'h3c, 8'hff, 8'h00},
    '{SW, 0, 5'h1f, 8'h00, 8'hf1, 1, 0, 8'h3c, 8'hff, 8'h1f},
    '{XF, 1, 5'h1f, 8'h00, 8'hf1, 0, 1, 8'h3c, 8'hff, 8'hee},
    '{XL, 0, 5'h00, 8'ha5, 8'h54, 0, 0, 8'h3c, 8'hff, 8'h00},
    '{DL, 0, 5'h07, 8'h00, 8'h54, 0, 0, 8'h3c, 8'h54, 8'h07},
    '{SW, 1, 5'h03, 8'h00, 8'h54, 0, 1, 8'h3c, 8'h54, 8'h30},
    '{XF, 0, 5'h03, 8'h00, 8'h64, 0, 0, 8'h3c, 8'h54, 8'h30},
    '{XL, 0, 5'h00, 8'h64, 8'h00, 1, 0, 8'h3c, 8'h54, 8'h00},
    '{DL, 0, 5'h05, 8'h00, 8'h00, 1, 0, 8'h3c, 8'h54, 8'h05},
    '{NSX_NOP, 1, 5'h02, 8'h00, 8'h00, 1, 0, 8'h3c, 8'h54, 8'h02},
    '{XF, 1, 5'h00, 8'h00, 8'h00, 1, 1, 8'h3c, 8'h54, 8'h00}
  };
  logic       clk = 0, arst_n = 0, opValid = 0, dest = 0;
  nsx_op_type op = NSX_NOP;
  logic [4:0] fileAddr = '0, rdA, wrA;
  logic [7:0] literal = '0, rdD, wrD, acc, dA, dB;
  logic       we, zf;
  int         bad_count = 0, check_count = 0;
  int         prevRow = -1;
  always #12.5 clk = ~clk;
  nsx_datapath dut (.clk(clk), .arst_n(arst_n), .opValid(opValid),
    .op(op), .dest(dest), .fileAddr(fileAddr), .literal(literal),
    .fileRdData(rdD), .fileRdAddr(rdA), .fileWe(we), .fileWrAddr(wrA),
    .fileWrData(wrD), .accOut(acc), .zeroFlag(zf), .dirAOut(dA),
    .dirBOut(dB));
  nsx_regfile_model rf (.clk(clk), .rdAddr(rdA), .rdData(rdD), .we(we),
    .wrAddr(wrA), .wrData(wrD));
  task automatic chk8(string n, logic [7:0] e, logic [7:0] g);
    check_count++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk1(string n, logic e, logic g);
    chk8(n, {7'h0, e}, {7'h0, g});
  endtask
  task automatic end_sim();
    if (bad_count == 0 && check_count > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 100 cycles
  initial begin
    #(25 * 400);
    bad_count++;
    end_sim();
  end
  initial begin
    repeat (20) @(negedge clk);
    arst_n = 1;
    opValid = 1;
    foreach (rows[i]) begin
      op = rows[i].op;
      dest = rows[i].dest;
      fileAddr = rows[i].addr;
      literal = rows[i].lit;
      #1 chk8("rdaddr", {3'h0, rows[i].addr}, {3'h0, rdA});
      @(negedge clk);
      chk8("acc", rows[i].acc, acc);
      chk1("zero", rows[i].z, zf);
      chk1("we", rows[i].we, we);
      chk8("dirA", rows[i].da, dA);
      chk8("dirB", rows[i].db, dB);
      if (rows[i].we) begin
        chk8("wraddr", {3'h0, rows[i].addr}, {3'h0, wrA});
        chk8("wrdata", rows[i].mem, wrD);
      end
      // the file write lands one edge later, so the word is checked a row on
      if (prevRow >= 0) begin
        chk8("mem", rows[prevRow].mem,
             rf.mem[rows[prevRow].addr]);
      end
      prevRow = i;
    end
    // write pulse must drop and acc must hold while an XL op is presented but not valid
    opValid = 1'b0;
    op = XL;
    literal = 8'h81;
    @(negedge clk);
    chk1("we idle", 1'b0, we);
    chk8("mem last", rows[prevRow].mem,
         rf.mem[rows[prevRow].addr]);
    chk8("acc idle", 8'h00, acc);
    opValid = 1;
    @(negedge clk);
    chk8("acc lit", 8'h81, acc);
    chk1("zero lit", 1'b0, zf);
    // reset in mid-run restores the chosen values at once
    {opValid, arst_n} = 2'b00;
    #1 chk8("acc rst", 8'h00, acc);
    chk8("dirA rst", 8'hff, dA);
    chk8("dirB rst", 8'hff, dB);
    chk1("zero rst", 1'b0, zf);
    @(negedge clk);
    // first op right after release must start from the reset accumulator
    arst_n = 1'b1;
    opValid = 1'b1;
    literal = 8'h5a;
    @(negedge clk);
    chk8("acc after rst", 8'h5a, acc);
    chk1("zero after rst", 1'b0, zf);
    chk8("dirA after rst", 8'hff, dA);
    end_sim();
  end
endmodule
`default_nettype wire
